/* File: logic/fbsd_pkg.sv */
package fbsd_pkg;
   // ****************************************
   // register bus
   // ****************************************
   localparam int          ADDR_W      = 8;
   localparam int          DATA_W      = 16;
   localparam logic [7:0]  A_CTRL      = 8'h00;
   localparam logic [7:0]  A_STAT      = 8'h01;
   localparam logic [7:0]  A_CYC_IMG   = 8'h02;
   localparam logic [7:0]  A_ACY_IMG   = 8'h03;
   localparam logic [7:0]  A_OPC_IMG   = 8'h04;
   localparam logic [7:0]  A_FRAMES    = 8'h05;
   localparam logic [3:0]  PG_CYC_SEL  = 4'h1;
   localparam logic [3:0]  PG_ACY_SEL  = 4'h2;
   localparam logic [3:0]  PG_OPC_SEL  = 4'h3;
   localparam logic [3:0]  PG_ANA_SEL  = 4'h4;
   // ****************************************
   // fields and reset values
   // ****************************************
   localparam int          CTRL_BT_LSB = 0;
   localparam int          STAT_BUSY   = 0;
   localparam int          STAT_OVR    = 1;
   localparam logic [1:0]  BT1         = 2'h1;
   localparam logic [1:0]  BT2         = 2'h2;
   localparam logic [1:0]  BT3         = 2'h3;
   localparam logic [1:0]  CTRL_BT_RST = 2'h3;
   localparam logic [4:0]  LEN_BT1     = 5'h0a;
   localparam logic [4:0]  LEN_BT2     = 5'h04;
   localparam logic [4:0]  LEN_BT3     = 5'h14;
   localparam logic [4:0]  BIN_BYTES   = 5'h02;
   localparam logic [7:0]  REC_NUM     = 8'hcb;
   localparam int          IMG_BITS    = 16;
   localparam int          BYTE0_BITS  = 8;
   localparam int          NWORDS      = 9;
   localparam int          WORD_AW     = 4;
   localparam int          BIN_SEL_W   = 7;
   localparam int          ANA_SEL_W   = 5;
   localparam logic [6:0]  BIN_NONE    = 7'h7f;
   localparam logic [4:0]  ANA_NONE    = 5'h1f;
   localparam logic [4:0]  ANA_IMAX    = 5'h00;
   localparam int          NBIN_DEF    = 64;
   localparam int          NANA_DEF    = 16;
   // ****************************************
   // send sequencer
   // ****************************************
   typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SEND = 1'b1} fbsd_tx_t;
endpackage

/* File: logic/fbsd_bit_sel.sv */
`timescale 1ns/10ps
module fbsd_bit_sel
   import fbsd_pkg::*;
#(
   parameter int NSRC = NBIN_DEF
)
(
   input  wire logic [NSRC-1:0]               i_pool,
   input  wire logic [IMG_BITS*BIN_SEL_W-1:0] i_sel,
   output logic      [IMG_BITS-1:0]           o_img
);
   // ****************************************
   // one selectable source per image bit
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < IMG_BITS; g++)
      begin : g_bit
         logic [BIN_SEL_W-1:0] s;
         assign s = i_sel[g*BIN_SEL_W +: BIN_SEL_W];
         // codes past the pool read as an open plug, i.e. zero
         assign o_img[g] = (int'(s) < NSRC) ? i_pool[int'(s)] : 1'b0;
      end
   endgenerate
endmodule

/* File: logic/fbsd_word_mem.sv */
`timescale 1ns/10ps
module fbsd_word_mem
   import fbsd_pkg::*;
#(
   parameter int DEPTH = NWORDS,
   parameter int W     = DATA_W
)
(
   input  wire logic                 i_mclk,
   input  wire logic                 i_rst,
   input  wire logic                 i_load,
   input  wire logic [DEPTH*W-1:0]   i_words,
   input  wire logic [WORD_AW-1:0]   i_raddr,
   output logic      [W-1:0]         o_rdata
);
   logic [W-1:0] mem_r [DEPTH];

   // ****************************************
   // all words load on one edge so a frame is coherent
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++)
      begin : g_word
         always_ff @(posedge i_mclk or posedge i_rst)
         begin
            if (i_rst)
               mem_r[g] <= '0;
            else if (i_load)
               mem_r[g] <= i_words[g*W +: W];
         end
      end
   endgenerate

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         o_rdata <= '0;
      else if (int'(i_raddr) < DEPTH)
         o_rdata <= mem_r[i_raddr];
      else
         o_rdata <= '0;
   end
endmodule

/* File: logic/fbsd_send_image.sv */
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module fbsd_send_image
   import fbsd_pkg::*;
#(
   parameter int NBIN = NBIN_DEF,
   parameter int NANA = NANA_DEF
)
(
   input  wire logic                   i_mclk,
   input  wire logic                   i_rst,
   input  wire logic [NBIN-1:0]        i_bin_pool,
   input  wire logic [NANA*DATA_W-1:0] i_ana_pool,
   input  wire logic [ADDR_W-1:0]      i_addr,
   input  wire logic [DATA_W-1:0]      i_wdata,
   input  wire logic                   i_wr,
   input  wire logic                   i_rd,
   output logic      [DATA_W-1:0]      o_rdata,
   input  wire logic                   i_cyc_req,
   output logic                        o_tx_valid,
   output logic      [7:0]             o_tx_byte,
   output logic                        o_tx_first,
   output logic                        o_tx_last,
   input  wire logic                   i_rec_req,
   input  wire logic [7:0]             i_rec_num,
   output logic                        o_rec_valid,
   output logic      [DATA_W-1:0]      o_rec_data,
   output logic                        o_rec_err,
   input  wire logic                   i_opc_req,
   output logic                        o_opc_valid,
   output logic      [DATA_W-1:0]      o_opc_data
);
   // ****************************************
   // declarations
   // ****************************************
   logic [BIN_SEL_W-1:0]           cyc_sel_r [IMG_BITS];
   logic [BIN_SEL_W-1:0]           acy_sel_r [IMG_BITS];
   logic [BIN_SEL_W-1:0]           opc_sel_r [IMG_BITS];
   logic [ANA_SEL_W-1:0]           ana_sel_r [NWORDS];
   logic [IMG_BITS*BIN_SEL_W-1:0]  cyc_sel_flat;
   logic [IMG_BITS*BIN_SEL_W-1:0]  acy_sel_flat;
   logic [IMG_BITS*BIN_SEL_W-1:0]  opc_sel_flat;
   logic [NWORDS*DATA_W-1:0]       ana_live;
   logic [IMG_BITS-1:0]            cyc_live;
   logic [IMG_BITS-1:0]            acy_live;
   logic [IMG_BITS-1:0]            opc_live;
   logic [1:0]                     btype_r;
   logic [IMG_BITS-1:0]            cyc_bin_r;
   logic [DATA_W-1:0]              frames_r;
   logic                           ovr_r;
   fbsd_tx_t                       state_r;
   logic [4:0]                     cnt_r;
   logic [4:0]                     len_r;
   logic [4:0]                     len_nxt;
   logic [4:0]                     wsub;
   logic [WORD_AW-1:0]             mem_raddr;
   logic [DATA_W-1:0]              mem_rdata;
   logic                           accept;
   logic                           p_valid_r;
   logic [4:0]                     p_cnt_r;
   logic                           p_last_r;
   logic                           wr_stat;

   // ****************************************
   // selector registers
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < IMG_BITS; g++)
      begin : g_bsel
         // byte 0 presets to the first eight pool signals, byte 1 starts open
         localparam logic [BIN_SEL_W-1:0] CYC_RV = (g < BYTE0_BITS) ? BIN_SEL_W'(g) : BIN_NONE;
         always_ff @(posedge i_mclk or posedge i_rst)
         begin
            if (i_rst)
               cyc_sel_r[g] <= CYC_RV;
            else if (i_wr && i_addr == {PG_CYC_SEL, 4'(g)})
               cyc_sel_r[g] <= i_wdata[BIN_SEL_W-1:0];
         end
         always_ff @(posedge i_mclk or posedge i_rst)
         begin
            if (i_rst)
               acy_sel_r[g] <= BIN_NONE;
            else if (i_wr && i_addr == {PG_ACY_SEL, 4'(g)})
               acy_sel_r[g] <= i_wdata[BIN_SEL_W-1:0];
         end
         always_ff @(posedge i_mclk or posedge i_rst)
         begin
            if (i_rst)
               opc_sel_r[g] <= BIN_NONE;
            else if (i_wr && i_addr == {PG_OPC_SEL, 4'(g)})
               opc_sel_r[g] <= i_wdata[BIN_SEL_W-1:0];
         end
         assign cyc_sel_flat[g*BIN_SEL_W +: BIN_SEL_W] = cyc_sel_r[g];
         assign acy_sel_flat[g*BIN_SEL_W +: BIN_SEL_W] = acy_sel_r[g];
         assign opc_sel_flat[g*BIN_SEL_W +: BIN_SEL_W] = opc_sel_r[g];
      end

      for (g = 0; g < NWORDS; g++)
      begin : g_asel
         // the first word presets to the peak phase current source
         localparam logic [ANA_SEL_W-1:0] ANA_RV = (g == 0) ? ANA_IMAX : ANA_NONE;
         always_ff @(posedge i_mclk or posedge i_rst)
         begin
            if (i_rst)
               ana_sel_r[g] <= ANA_RV;
            else if (i_wr && i_addr == {PG_ANA_SEL, 4'(g)})
               ana_sel_r[g] <= i_wdata[ANA_SEL_W-1:0];
         end
         assign ana_live[g*DATA_W +: DATA_W] =
            (int'(ana_sel_r[g]) < NANA) ? i_ana_pool[DATA_W*int'(ana_sel_r[g]) +: DATA_W] : '0;
      end
   endgenerate

   // ****************************************
   // image builders
   // ****************************************
   fbsd_bit_sel #(.NSRC(NBIN)) u_cyc_sel
   (
      .i_pool (i_bin_pool),
      .i_sel  (cyc_sel_flat),
      .o_img  (cyc_live)
   );

   fbsd_bit_sel #(.NSRC(NBIN)) u_acy_sel
   (
      .i_pool (i_bin_pool),
      .i_sel  (acy_sel_flat),
      .o_img  (acy_live)
   );

   fbsd_bit_sel #(.NSRC(NBIN)) u_opc_sel
   (
      .i_pool (i_bin_pool),
      .i_sel  (opc_sel_flat),
      .o_img  (opc_live)
   );

   // ****************************************
   // control and status
   // ****************************************
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         btype_r <= CTRL_BT_RST;
      else if (i_wr && i_addr == A_CTRL)
         btype_r <= i_wdata[CTRL_BT_LSB +: 2];
   end

   assign wr_stat = i_wr && (i_addr == A_STAT);

   // a request that lands while the sequencer is in TX_SEND is dropped and flagged
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         ovr_r <= 1'b0;
      else if (i_cyc_req && state_r == TX_SEND)
         ovr_r <= 1'b1;
      else if (wr_stat && i_wdata[STAT_OVR])
         ovr_r <= 1'b0;
   end

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         frames_r <= '0;
      else if (accept)
         frames_r <= frames_r + 16'h0001;
   end

   // ****************************************
   // cyclic frame length by basic type
   // ****************************************
   always_comb
   begin
      if (btype_r == BT3)
         len_nxt = LEN_BT3;
      else if (btype_r == BT1)
         len_nxt = LEN_BT1;
      else
         len_nxt = LEN_BT2;
   end

   // ****************************************
   // cyclic snapshot and send sequencer
   // ****************************************
   assign accept = i_cyc_req && (state_r == TX_IDLE);

   // binary bits and all analog words freeze on the accepting edge
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         cyc_bin_r <= '0;
      else if (accept)
         cyc_bin_r <= cyc_live;
   end

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_r <= TX_IDLE;
         cnt_r   <= '0;
         len_r   <= LEN_BT2;
      end
      else
      begin
         case (state_r)
            TX_IDLE:
            begin
               if (accept)
               begin
                  state_r <= TX_SEND;
                  cnt_r   <= '0;
                  len_r   <= len_nxt;
               end
            end
            TX_SEND:
            begin
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r == len_r - 5'h01)
                  state_r <= TX_IDLE;
            end
            default:
               state_r <= TX_IDLE;
         endcase
      end
   end

   assign wsub      = cnt_r - BIN_BYTES;
   assign mem_raddr = wsub[4:1];

   fbsd_word_mem #(.DEPTH(NWORDS), .W(DATA_W)) u_words
   (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_load  (accept),
      .i_words (ana_live),
      .i_raddr (mem_raddr),
      .o_rdata (mem_rdata)
   );

   // one stage waits for the registered word read
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         p_valid_r <= 1'b0;
         p_cnt_r   <= '0;
         p_last_r  <= 1'b0;
      end
      else
      begin
         p_valid_r <= (state_r == TX_SEND);
         p_cnt_r   <= cnt_r;
         p_last_r  <= (state_r == TX_SEND) && (cnt_r == len_r - 5'h01);
      end
   end

   // analog words go out high byte first
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_tx_valid <= 1'b0;
         o_tx_byte  <= '0;
         o_tx_first <= 1'b0;
         o_tx_last  <= 1'b0;
      end
      else
      begin
         o_tx_valid <= p_valid_r;
         o_tx_first <= p_valid_r && (p_cnt_r == 5'h00);
         o_tx_last  <= p_last_r;
         if (!p_valid_r)
            o_tx_byte <= '0;
         else if (p_cnt_r == 5'h00)
            o_tx_byte <= cyc_bin_r[7:0];
         else if (p_cnt_r == 5'h01)
            o_tx_byte <= cyc_bin_r[15:8];
         else if (p_cnt_r[0] == 1'b0)
            o_tx_byte <= mem_rdata[15:8];
         else
            o_tx_byte <= mem_rdata[7:0];
      end
   end

   // ****************************************
   // acyclic record and opc image
   // ****************************************
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_rec_valid <= 1'b0;
         o_rec_err   <= 1'b0;
         o_rec_data  <= '0;
      end
      else
      begin
         o_rec_valid <= i_rec_req && (i_rec_num == REC_NUM);
         o_rec_err   <= i_rec_req && (i_rec_num != REC_NUM);
         if (i_rec_req && i_rec_num == REC_NUM)
            o_rec_data <= acy_live;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_opc_valid <= 1'b0;
         o_opc_data  <= '0;
      end
      else
      begin
         o_opc_valid <= i_opc_req;
         if (i_opc_req)
            o_opc_data <= opc_live;
      end
   end

   // ****************************************
   // register read port
   // ****************************************
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         o_rdata <= '0;
      else if (!i_rd)
         o_rdata <= '0;
      else if (i_addr == A_CTRL)
         o_rdata <= {14'h0000, btype_r};
      else if (i_addr == A_STAT)
         o_rdata <= {14'h0000, ovr_r, (state_r == TX_SEND) || p_valid_r || o_tx_valid};
      else if (i_addr == A_CYC_IMG)
         o_rdata <= cyc_bin_r;
      else if (i_addr == A_ACY_IMG)
         o_rdata <= acy_live;
      else if (i_addr == A_OPC_IMG)
         o_rdata <= opc_live;
      else if (i_addr == A_FRAMES)
         o_rdata <= frames_r;
      else if (i_addr[7:4] == PG_CYC_SEL)
         o_rdata <= {9'h000, cyc_sel_r[i_addr[3:0]]};
      else if (i_addr[7:4] == PG_ACY_SEL)
         o_rdata <= {9'h000, acy_sel_r[i_addr[3:0]]};
      else if (i_addr[7:4] == PG_OPC_SEL)
         o_rdata <= {9'h000, opc_sel_r[i_addr[3:0]]};
      else if (i_addr[7:4] == PG_ANA_SEL && int'(i_addr[3:0]) < NWORDS)
         o_rdata <= {11'h000, ana_sel_r[i_addr[3:0]]};
      else
         o_rdata <= '0;
   end
endmodule

/* File: verification/fbsd_send_image_assertions.sv */
`timescale 1ns/10ps
module fbsd_send_image_chk
   import fbsd_pkg::*;
#(
   parameter int NBIN = NBIN_DEF,
   parameter int NANA = NANA_DEF
)
(
   input wire logic                   i_mclk,
   input wire logic                   i_rst,
   input wire logic [NBIN-1:0]        i_bin_pool,
   input wire logic [NANA*DATA_W-1:0] i_ana_pool,
   input wire logic [ADDR_W-1:0]      i_addr,
   input wire logic [DATA_W-1:0]      i_wdata,
   input wire logic                   i_wr,
   input wire logic                   i_rd,
   input wire logic [DATA_W-1:0]      o_rdata,
   input wire logic                   i_cyc_req,
   input wire logic                   o_tx_valid,
   input wire logic [7:0]             o_tx_byte,
   input wire logic                   o_tx_first,
   input wire logic                   o_tx_last,
   input wire logic                   i_rec_req,
   input wire logic [7:0]             i_rec_num,
   input wire logic                   o_rec_valid,
   input wire logic [DATA_W-1:0]      o_rec_data,
   input wire logic                   o_rec_err,
   input wire logic                   i_opc_req,
   input wire logic                   o_opc_valid,
   input wire logic [DATA_W-1:0]      o_opc_data
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   // ****************************************
   // byte counter of the running frame
   // ****************************************
   logic [4:0] cnt_r;
   always_ff @(posedge i_mclk or posedge i_rst)
      if (i_rst)
         cnt_r <= 5'h00;
      else if (o_tx_valid)
         cnt_r <= o_tx_first ? 5'h01 : cnt_r + 5'h01;
      else
         cnt_r <= 5'h00;
   chk_rdata_one_cycle: assert property (o_rdata != 16'h0000 |-> $past(i_rd)) else $error("read data out of slot");
   chk_idle_byte_zero: assert property (!o_tx_valid |-> o_tx_byte == 8'h00) else $error("idle byte not zero");
   chk_first_delay: assert property (o_tx_first |-> o_tx_valid && $past(i_cyc_req, 3)) else $error("first late");
   chk_frame_contig: assert property (o_tx_valid && !o_tx_last |=> o_tx_valid) else $error("frame gap");
   chk_frame_length: assert property (o_tx_last |-> cnt_r == LEN_BT1 - 5'h01 || cnt_r == LEN_BT2 - 5'h01
      || cnt_r == LEN_BT3 - 5'h01) else $error("frame length");
   chk_rec_good: assert property (i_rec_req && i_rec_num == REC_NUM |=> o_rec_valid && !o_rec_err)
      else $error("record not answered");
   chk_rec_bad: assert property (i_rec_req && i_rec_num != REC_NUM |=> o_rec_err && !o_rec_valid)
      else $error("bad record answered");
   chk_rec_cause: assert property (o_rec_valid |-> $past(i_rec_req)) else $error("record unasked");
   chk_rec_hold: assert property (!o_rec_valid |-> $stable(o_rec_data)) else $error("record data moved");
   chk_opc_answer: assert property (i_opc_req |=> o_opc_valid ##1 (!o_opc_valid || $past(i_opc_req)))
      else $error("opc answer");
endmodule
bind fbsd_send_image fbsd_send_image_chk #(.NBIN(NBIN), .NANA(NANA)) chk_u (.i_mclk(i_mclk), .i_rst(i_rst),
   .i_bin_pool(i_bin_pool), .i_ana_pool(i_ana_pool), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .i_cyc_req(i_cyc_req), .o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte),
   .o_tx_first(o_tx_first), .o_tx_last(o_tx_last), .i_rec_req(i_rec_req), .i_rec_num(i_rec_num),
   .o_rec_valid(o_rec_valid), .o_rec_data(o_rec_data), .o_rec_err(o_rec_err), .i_opc_req(i_opc_req),
   .o_opc_valid(o_opc_valid), .o_opc_data(o_opc_data));

/* File: verification/fbsd_master_mdl.sv */
`timescale 1ns/10ps
module fbsd_master_mdl
(
   input  wire logic       i_mclk,
   input  wire logic       i_rst,
   input  wire logic       i_start,
   output logic            o_cyc_req,
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_byte,
   input  wire logic       i_tx_first,
   input  wire logic       i_tx_last,
   output logic [7:0]      o_frame [20],
   output logic [4:0]      o_len,
   output logic            o_done
);
   // ****************************************
   // one delivery per bus cycle, then collect the answer
   // ****************************************
   logic [4:0] idx_w;
   logic [4:0] idx_r;
   assign idx_w = i_tx_first ? 5'h00 : idx_r;
   always_ff @(posedge i_mclk or posedge i_rst)
      if (i_rst)
         o_cyc_req <= 1'b0;
      else
         o_cyc_req <= i_start;
   // bytes past the last one are dropped, a long frame shows up in o_len
   always_ff @(posedge i_mclk or posedge i_rst)
      if (i_rst)
      begin
         idx_r  <= 5'h00;
         o_len  <= 5'h00;
         o_done <= 1'b0;
      end
      else if (i_start)
         o_done <= 1'b0;
      else if (i_tx_valid)
      begin
         o_frame[idx_w] <= i_tx_byte;
         idx_r          <= idx_w + 5'h01;
         o_done         <= i_tx_last;
         o_len          <= idx_w + 5'h01;
      end
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
   import fbsd_pkg::*;
   logic i_mclk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, st = 1'b0, i_cyc_req;
   logic i_rec_req = 1'b0, i_opc_req = 1'b0, o_tx_valid, o_tx_first, o_tx_last, done;
   logic o_rec_valid, o_rec_err, o_opc_valid;
   logic [63:0] bin = 64'h0123_4567_89ab_cdef;
   logic [255:0] ana;
   logic [7:0] i_addr = 8'h00, i_rec_num = 8'h00, o_tx_byte, frm [20];
   logic [15:0] i_wdata = 16'h0000, o_rdata, o_rec_data, o_opc_data;
   logic [4:0] flen;
   int failures = 0, comparisons = 0;
   always #12.5 i_mclk = ~i_mclk;
   fbsd_send_image dut_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_bin_pool(bin), .i_ana_pool(ana), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cyc_req(i_cyc_req),
      .o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte), .o_tx_first(o_tx_first), .o_tx_last(o_tx_last),
      .i_rec_req(i_rec_req), .i_rec_num(i_rec_num), .o_rec_valid(o_rec_valid), .o_rec_data(o_rec_data),
      .o_rec_err(o_rec_err), .i_opc_req(i_opc_req), .o_opc_valid(o_opc_valid), .o_opc_data(o_opc_data));
   fbsd_master_mdl mdl_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_start(st), .o_cyc_req(i_cyc_req),
      .i_tx_valid(o_tx_valid), .i_tx_byte(o_tx_byte), .i_tx_first(o_tx_first), .i_tx_last(o_tx_last),
      .o_frame(frm), .o_len(flen), .o_done(done));
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 cmp(o_rdata, exp);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   // sources move on the accepting edge itself, after it samples them, so the frame must show the old ones
   task automatic t_frame(input logic [1:0] bt, input logic [4:0] len, input logic full, input logic twice);
      logic [63:0] b0;
      logic [255:0] a0;
      logic [15:0] w;
      wr(A_CTRL, {14'h0000, bt});
      b0 = bin;
      a0 = ana;
      @(posedge i_mclk) st <= 1'b1;
      @(posedge i_mclk) st <= twice;
      @(posedge i_mclk) st <= 1'b0;
      bin <= ~bin;
      ana <= ~ana;
      for (int n = 0; n < 40 && !done; n++)
         @(posedge i_mclk);
      #1 cmp({11'h000, flen}, {11'h000, len});
      cmp({8'h00, frm[0]}, {8'h00, b0[7:0]});
      cmp({8'h00, frm[1]}, full ? {8'h00, b0[15:8]} : 16'h0000);
      for (int i = 2; i < len; i += 2)
      begin
         w = (full || i == 2) ? a0[(i-2)*8 +: 16] : 16'h0000;
         cmp({frm[i], frm[i+1]}, w);
      end
      @(posedge i_mclk) bin <= b0;
      ana <= a0;
   endtask
   task automatic t_side;
      for (int n = 0; n < 16; n++)
      begin
         wr(8'h20 + 8'(n), 16'(16 + n));
         wr(8'h30 + 8'(n), 16'(32 + n));
      end
      rd(A_ACY_IMG, bin[31:16]);
      rd(A_OPC_IMG, bin[47:32]);
      @(posedge i_mclk);
      i_rec_req <= 1'b1;
      i_rec_num <= REC_NUM;
      i_opc_req <= 1'b1;
      @(posedge i_mclk) i_rec_num <= 8'hca;
      i_opc_req <= 1'b0;
      #1 cmp({o_rec_valid, o_rec_err, o_opc_valid}, 16'h0005);
      cmp(o_rec_data, bin[31:16]);
      cmp(o_opc_data, bin[47:32]);
      @(posedge i_mclk) i_rec_req <= 1'b0;
      #1 cmp({o_rec_valid, o_rec_err}, 16'h0001);
      cmp(o_rec_data, bin[31:16]);
   endtask
   initial
   begin
      for (int k = 0; k < 16; k++)
         ana[16*k +: 16] = {4'ha, 4'(k), 8'h5c};
      repeat (10) @(posedge i_mclk);
      i_rst <= 1'b0;
      rd(A_CTRL, {14'h0000, CTRL_BT_RST});
      rd(8'h17, 16'h0007);
      rd(8'h18, {9'h000, BIN_NONE});
      rd(8'h40, {11'h000, ANA_IMAX});
      rd(8'h41, {11'h000, ANA_NONE});
      rd(8'hff, 16'h0000);
      t_frame(BT3, LEN_BT3, 1'b0, 1'b0);
      for (int n = 8; n < 16; n++)
         wr(8'h10 + 8'(n), 16'(n));
      for (int k = 0; k < 9; k++)
         wr(8'h40 + 8'(k), 16'(k));
      t_frame(BT1, LEN_BT1, 1'b1, 1'b0);
      t_frame(BT2, LEN_BT2, 1'b1, 1'b0);
      t_frame(2'h0, LEN_BT2, 1'b1, 1'b0);
      t_frame(BT3, LEN_BT3, 1'b1, 1'b1);
      rd(A_STAT, 16'h0002);
      wr(A_STAT, 16'h0002);
      rd(A_STAT, 16'h0000);
      rd(A_CYC_IMG, bin[15:0]);
      rd(A_FRAMES, 16'h0005);
      t_side;
      give_verdict;
   end
   initial
   begin
      repeat (5000) @(posedge i_mclk);
      failures++;
      give_verdict;
   end
endmodule
